// ### port_input_buffer_select_pkg.sv
package port_input_buffer_select_pkg;
    localparam int unsigned REG_WIDTH = 8;
    localparam logic [31:0] PORT_B_OFFSET = 32'h0000_0000;
    localparam logic [31:0] PORT_C_OFFSET = 32'h0000_0004;
    localparam logic [31:0] PORT_D_OFFSET = 32'h0000_0008;
    localparam logic [7:0] PORT_B_IMPL_MASK = 8'h3f;
    localparam logic [7:0] PORT_C_IMPL_MASK = 8'hfc;
    localparam logic [7:0] PORT_D_IMPL_MASK = 8'hff;
    localparam logic [7:0] PORT_B_RESET = 8'h3f;
    localparam logic [7:0] PORT_C_RESET = 8'hfc;
    localparam logic [7:0] PORT_D_RESET = 8'hff;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : port_input_buffer_select_pkg

// ### select_reg.sv
`timescale 1ns/1ps
module select_reg #(
    parameter logic [7:0] IMPL_MASK = 8'hff,
    parameter logic [7:0] RESET_VAL = 8'hff
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    logic [7:0] value_r;
    logic [7:0] value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (wr_en) begin
            value_nxt = wr_data & IMPL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_r <= RESET_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

    // Unimplemented bits never store, so they read zero
    assign value = value_r & IMPL_MASK;
endmodule : select_reg

// ### port_input_buffer_select.sv
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Bits 7 and 6 of the port B select register are absent and read zero.
// - Port B bits 5..0 each turn the matching pin's digital input buffer off when one, on when zero.
// - Port C bits 7..2 each turn the matching pin's digital input buffer off when one, on when zero.
// - Bits 1 and 0 of the port C select register are absent and read zero.
// - Port D bits 7..0 each turn the matching pin's digital input buffer off when one, on when zero.
module port_input_buffer_select (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] port_b_buffer_off,
    output logic [7:0] port_c_buffer_off,
    output logic [7:0] port_d_buffer_off
);
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [3:0] wr_addr_r;
    logic [3:0] wr_addr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic access;
    logic [7:0] b_val;
    logic [7:0] c_val;
    logic [7:0] d_val;
    logic wr_b;
    logic wr_c;
    logic wr_d;

    assign access = hsel && hready && (htrans == port_input_buffer_select_pkg::HTRANS_NONSEQ ||
                                       htrans == port_input_buffer_select_pkg::HTRANS_SEQ);

    // Write data arrives one cycle after the address, so the address is held
    always_comb begin
        wr_pend_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        hrdata_nxt = hrdata_r;
        if (access) begin
            wr_pend_nxt = hwrite;
            wr_addr_nxt = haddr[3:0];
            if (!hwrite) begin
                case (haddr[3:0])
                    port_input_buffer_select_pkg::PORT_B_OFFSET[3:0]: hrdata_nxt = {24'h000000, b_val};
                    port_input_buffer_select_pkg::PORT_C_OFFSET[3:0]: hrdata_nxt = {24'h000000, c_val};
                    port_input_buffer_select_pkg::PORT_D_OFFSET[3:0]: hrdata_nxt = {24'h000000, d_val};
                    default: hrdata_nxt = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 4'h0;
            hrdata_r <= 32'h00000000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign wr_b = wr_pend_r && wr_addr_r == port_input_buffer_select_pkg::PORT_B_OFFSET[3:0];
    assign wr_c = wr_pend_r && wr_addr_r == port_input_buffer_select_pkg::PORT_C_OFFSET[3:0];
    assign wr_d = wr_pend_r && wr_addr_r == port_input_buffer_select_pkg::PORT_D_OFFSET[3:0];

    select_reg #(
        .IMPL_MASK(port_input_buffer_select_pkg::PORT_B_IMPL_MASK),
        .RESET_VAL(port_input_buffer_select_pkg::PORT_B_RESET)
    ) u_port_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_b),
        .wr_data(hwdata[7:0]),
        .value(b_val)
    );

    select_reg #(
        .IMPL_MASK(port_input_buffer_select_pkg::PORT_C_IMPL_MASK),
        .RESET_VAL(port_input_buffer_select_pkg::PORT_C_RESET)
    ) u_port_c (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_c),
        .wr_data(hwdata[7:0]),
        .value(c_val)
    );

    select_reg #(
        .IMPL_MASK(port_input_buffer_select_pkg::PORT_D_IMPL_MASK),
        .RESET_VAL(port_input_buffer_select_pkg::PORT_D_RESET)
    ) u_port_d (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_d),
        .wr_data(hwdata[7:0]),
        .value(d_val)
    );

    assign port_b_buffer_off = b_val;
    assign port_c_buffer_off = c_val;
    assign port_d_buffer_off = d_val;
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule : port_input_buffer_select

// ### pibs_monitor.sv
`timescale 1ns/1ps
module pibs_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic [7:0] port_b_buffer_off,
    input wire logic [7:0] port_c_buffer_off,
    input wire logic [7:0] port_d_buffer_off
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_b_top_zero: assert property (port_b_buffer_off[7:6] == 2'h0) else $error("b top set");
    a_c_low_zero: assert property (port_c_buffer_off[1:0] == 2'h0) else $error("c low set");
    a_b_write_only: assert property ($changed(port_b_buffer_off) |-> $past(hsel && hwrite, 2))
        else $error("b changed unwritten");
    a_c_write_only: assert property ($changed(port_c_buffer_off) |-> $past(hsel && hwrite, 2))
        else $error("c changed unwritten");
    a_d_write_only: assert property ($changed(port_d_buffer_off) |-> $past(hsel && hwrite, 2))
        else $error("d changed unwritten");
    a_reset_ones: assert property ($rose(hresetn) |-> hreadyout && port_b_buffer_off == 8'h3f
        && port_c_buffer_off == 8'hfc && port_d_buffer_off == 8'hff) else $error("bad reset value");
    cover property ($fell(port_b_buffer_off[0]));
    cover property ($changed(port_c_buffer_off));
    cover property ($rose(port_d_buffer_off[7]));
endmodule : pibs_monitor

// ### tb_port_input_buffer_select.sv
`timescale 1ns/1ps
module tb_port_input_buffer_select;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [23:0] pins;
    logic [31:0] offs [3] = '{32'h0, 32'h4, 32'h8};
    logic [7:0] msk [3] = '{8'h3f, 8'hfc, 8'hff};
    logic [7:0] pat [3] = '{8'h00, 8'hff, 8'h5a};
    int errors = 0, total_checks = 0;
    always #12.5 hclk = ~hclk;
    port_input_buffer_select dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_b_buffer_off(pins[7:0]),
        .port_c_buffer_off(pins[15:8]), .port_d_buffer_off(pins[23:16]));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk("hrdata", r, e);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : rd
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 3; i++) begin
            rd(offs[i], {24'h0, msk[i]});
            chk("pins", {24'h0, pins[i*8 +: 8]}, {24'h0, msk[i]});
            foreach (pat[j]) begin
                xfer(1'b1, offs[i], {24'hffffff, pat[j]});
                rd(offs[i], {24'h0, pat[j] & msk[i]});
                chk("pins", {24'h0, pins[i*8 +: 8]}, {24'h0, pat[j] & msk[i]});
            end
        end
        xfer(1'b1, 32'hc, 32'hff);
        rd(32'hc, 32'h0);
        rd(offs[2], 32'h5a);
        close_out();
    end
    initial begin
        repeat (2000) @(posedge hclk);
        errors++;
        close_out();
    end
endmodule : tb_port_input_buffer_select
bind port_input_buffer_select pibs_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .hwrite(hwrite), .hreadyout(hreadyout), .port_b_buffer_off(port_b_buffer_off),
    .port_c_buffer_off(port_c_buffer_off), .port_d_buffer_off(port_d_buffer_off));
